// file: src/rst_wdt_pkg.sv
// shared constants, types and register map of the reset and watchdog block
package rst_wdt_pkg;

    // register map, byte-wide registers on the plain register port
    localparam logic [7:0] ADDR_RESET_SOURCE     = 8'h00;  // reset_source_register
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h01;  // watchdog_control

    // reset_source_register field positions
    localparam int BIT_PIN_FLAG   = 0;  // pin_reset_flag
    localparam int BIT_POWER_FLAG = 1;  // power_on_flag / monitor select
    localparam int BIT_CLK_LOSS   = 2;  // clock_loss_flag / detector enable
    localparam int BIT_WDT_FLAG   = 3;  // watchdog cause flag
    localparam int BIT_COMP       = 5;  // comparator_reset_enable_flag
    localparam int BIT_CNV        = 6;  // convert_start_reset_enable_flag

    // watchdog_control field positions and commands
    localparam int         BIT_WDT_STATUS   = 4;       // reads watchdog active
    localparam int         BIT_WDT_MODE     = 7;       // must be zero for interval write
    localparam logic [7:0] WDT_CMD_ENABLE   = 8'hA5;   // enable and restart
    localparam logic [7:0] WDT_CMD_DISARM   = 8'hDE;   // first disable byte
    localparam logic [7:0] WDT_CMD_DISABLE  = 8'hAD;   // second disable byte
    localparam logic [7:0] WDT_CMD_LOCK     = 8'hFF;   // lock out disable
    localparam logic [2:0] WDT_INTERVAL_RST = 3'h7;    // longest interval
    localparam logic [2:0] WDT_DISARM_CLKS  = 3'h4;    // window for second byte
    localparam int         WDT_WIDTH        = 21;      // counter width
    localparam int         WDT_BASE_EXP     = 3;       // timeout is 4**(3+field)

    // timing
    localparam int CLK_FREQ_HZ        = 50_000_000;                    // core clock
    localparam int PIN_HOLD_CYCLES    = 12;                            // after pin release
    localparam int SUPPLY_TIMEOUT_MS  = 100;                           // monitor timeout
    localparam int SUPPLY_HOLD_CYCLES = SUPPLY_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

    // reset sequencer states
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,   // executing
        ST_HOLD = 2'b01,   // in reset, sources or stretchers active
        ST_EXIT = 2'b10    // latch cause flags, then release
    } seq_state_e;

    // one bit per reset source
    typedef struct packed {
        logic cnv;        // convert-start input low
        logic comp;       // comparator low
        logic wdt;        // watchdog overflow
        logic clk_loss;   // missing clock one-shot
        logic power;      // supply monitor / power-on
        logic pin;        // external reset pin low
    } cause_s;

    // register port request
    typedef struct packed {
        logic [7:0] addr;   // register address
        logic [7:0] wdata;  // write data
        logic       wr;     // write strobe
        logic       rd;     // read strobe
    } reg_req_s;

endpackage

// file: src/reset_stretch.sv
// holds a busy level for a fixed number of cycles after its hold input drops
`timescale 1ns/1ns
module reset_stretch #(
    parameter int   HOLD       = 12,                  // cycles after release
    parameter int   WIDTH      = $clog2(HOLD + 1),    // counter width
    parameter logic START_BUSY = 1'b0                 // busy out of reset
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic hold_i,   // level that restarts the stretch
    output logic      busy_o    // high while held or counting
);
    // whole state of this module
    typedef struct packed {
        logic [WIDTH-1:0] cnt;   // cycles since release
        logic             busy;  // stretch running
    } stretch_s;

    stretch_s s_reg;   // registered state
    stretch_s s_next;  // next state

    // count out the hold time once the source is gone
    always_comb begin
        s_next = s_reg;
        if (hold_i) begin
            s_next.cnt  = '0;
            s_next.busy = 1'b1;
        end else if (s_reg.busy) begin
            if (s_reg.cnt == WIDTH'(HOLD - 1)) begin
                s_next.busy = 1'b0;
            end else begin
                s_next.cnt = s_reg.cnt + WIDTH'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{cnt: '0, busy: START_BUSY};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy_o = s_reg.busy;
endmodule

// file: src/watchdog_counter.sv
// programmable-interval watchdog counter with a one-cycle overflow pulse
`timescale 1ns/1ns
module watchdog_counter
    import rst_wdt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear_i,     // restart count from zero
    input  wire logic       run_i,       // watchdog active
    input  wire logic [2:0] interval_i,  // timeout select
    output logic            overflow_o   // one-cycle overflow pulse
);
    // whole state of this module
    typedef struct packed {
        logic [WDT_WIDTH-1:0] cnt;  // elapsed clocks
        logic                 ovf;  // overflow pulse
    } wdt_s;

    wdt_s                 s_reg;   // registered state
    wdt_s                 s_next;  // next state
    logic [WDT_WIDTH-1:0] last;    // final count of the interval
    logic [4:0]           shamt;   // log2 of the interval

    // count system clocks, overflow after 4**(3+field) of them
    always_comb begin
        shamt  = 5'(2 * WDT_BASE_EXP) + {1'b0, interval_i, 1'b0};
        last   = (WDT_WIDTH'(1) << shamt) - WDT_WIDTH'(1);
        s_next = s_reg;
        s_next.ovf = 1'b0;
        if (clear_i) begin
            s_next.cnt = '0;
        end else if (run_i) begin
            if (s_reg.cnt >= last) begin
                s_next.cnt = '0;
                s_next.ovf = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + WDT_WIDTH'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign overflow_o = s_reg.ovf;
endmodule

// file: src/reset_source_and_watchdog.sv
// reset source merging, cause flags, reset pin drive and watchdog control
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns

// Notes on behaviour
// - reset loads defaults, port latches all ones
// - reset halts execution, interrupts, timers
// - data memory untouched; stack pointer reinitialised
// - exit: default clock, fetch zero once stable
// - supply reset drives pin low through timeout
// - monitor source kept only when bit written one
// - power-on sets its flag; others clear it
// - supply drop resets; recovery like power-on
// - pin low resets; twelve cycles; pin flag
// - clock-loss enable, reset, flag, pin untouched
// - comparator low resets when enabled; reads one
// - convert-start low resets when enabled; blocks conversions
// - 21-bit watchdog overflow resets, pin untouched
// - after reset watchdog runs, interval 111
// - 0xA5 enables and restarts watchdog
// - 0xDE then 0xAD within four clocks disables
// - 0xFF locks disable until next reset
// - low bits set interval, readable; bit7 zero
module reset_source_and_watchdog
    import rst_wdt_pkg::*;
#(
    parameter int SUPPLY_HOLD = SUPPLY_HOLD_CYCLES,  // supply timeout in clocks
    parameter int PIN_HOLD    = PIN_HOLD_CYCLES      // pin release stretch
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_B,
    input  wire rst_wdt_pkg::reg_req_s REQ,
    output logic [7:0]                 RDATA,
    input  wire logic                  SUPPLY_MONITOR_ENABLE_PIN,
    input  wire logic                  SUPPLY_LOW,
    input  wire logic                  RST_PIN_IN,
    output logic                       RST_PIN_OUT,
    output logic                       RST_PIN_OE,
    input  wire logic                  CLK_MISSING,
    input  wire logic                  CLK_STABLE,
    input  wire logic                  COMP_OUT,
    input  wire logic                  CONVERT_START_INPUT,
    output logic                       CNV_TO_ADC,
    output logic                       CORE_RST_B,
    output logic                       EXEC_HALT,
    output logic                       PORT_LATCH_SET
);
    import rst_wdt_pkg::*;

    // whole state of the sequencer and its registers
    typedef struct packed {
        seq_state_e st;            // sequencer state
        cause_s     cause;         // sources seen during this reset
        logic       flag_pin;      // pin_reset_flag
        logic       flag_power;    // power_on_flag
        logic       flag_wdt;      // watchdog cause flag
        logic       mon_sel;       // supply monitor selected as source
        logic       clk_loss_en;   // clock_loss_flag, also detector enable
        logic       comp_en;       // comparator_reset_enable_flag
        logic       cnv_en;        // convert_start_reset_enable_flag
        logic       wdt_active;    // watchdog running
        logic       wdt_lock;      // disable locked out
        logic [2:0] wdt_interval;  // timeout select
        logic [2:0] disarm;        // clocks left for second disable byte
        logic [7:0] rdata;         // read data register
        logic       core_rst_b;    // core and register reset, low active
        logic       exec_halt;     // instruction fetch held off
        logic       port_set;      // port latches forced high
        logic       pin_oe;        // drive reset pin low
        logic       cnv_adc;       // convert start passed to converter
    } seq_s;

    // value held on asynchronous reset: power-on in progress
    localparam seq_s SEQ_RESET = '{
        st: ST_HOLD, cause: '{power: 1'b1, default: 1'b0},
        mon_sel: 1'b1, wdt_active: 1'b1, wdt_interval: WDT_INTERVAL_RST,
        exec_halt: 1'b1, port_set: 1'b1, pin_oe: 1'b1, cnv_adc: 1'b1,
        default: '0
    };

    seq_s   s_reg;        // registered state
    seq_s   s_next;       // next state
    cause_s req;          // live reset requests
    logic   any_req;      // any request present
    logic   rst_meta;     // reset synchroniser first stage
    logic   rst_n_sync;   // released reset for the whole block
    logic   pin_busy;     // pin release stretch running
    logic   supply_busy;  // supply timeout running
    logic   wdt_ovf;      // watchdog overflow pulse
    logic   wdt_clear;    // restart watchdog count
    logic   wr_wdt;       // write to watchdog_control
    logic   wr_src;       // write to reset_source_register
    logic   go_run;       // next state releases the core

    // reset release through two flip-flops
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta   <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    // live reset requests from every source
    always_comb begin
        req.power    = SUPPLY_LOW & SUPPLY_MONITOR_ENABLE_PIN & s_reg.mon_sel;
        req.pin      = ~RST_PIN_IN & ~s_reg.pin_oe;
        req.clk_loss = s_reg.clk_loss_en & CLK_MISSING;
        req.comp     = s_reg.comp_en & ~COMP_OUT;
        req.cnv      = s_reg.cnv_en & ~CONVERT_START_INPUT;
        req.wdt      = wdt_ovf;
        any_req      = |req;
    end

    // twelve clocks of reset after the pin is let go
    reset_stretch #(
        .HOLD       (PIN_HOLD),
        .WIDTH      ($clog2(PIN_HOLD + 1)),
        .START_BUSY (1'b0)
    ) u_pin_stretch (
        .clk    (CORE_CLK),
        .rst_n  (rst_n_sync),
        .hold_i (req.pin),
        .busy_o (pin_busy)
    );

    // supply timeout after the supply recovers, also from power-on
    reset_stretch #(
        .HOLD       (SUPPLY_HOLD),
        .WIDTH      ($clog2(SUPPLY_HOLD + 1)),
        .START_BUSY (1'b1)
    ) u_supply_stretch (
        .clk    (CORE_CLK),
        .rst_n  (rst_n_sync),
        .hold_i (req.power),
        .busy_o (supply_busy)
    );

    // watchdog restarts on any reset and on the enable command
    assign wdt_clear = (s_reg.st != ST_RUN) | (wr_wdt & (REQ.wdata == WDT_CMD_ENABLE));

    watchdog_counter u_wdt (
        .clk        (CORE_CLK),
        .rst_n      (rst_n_sync),
        .clear_i    (wdt_clear),
        .run_i      (s_reg.wdt_active),
        .interval_i (s_reg.wdt_interval),
        .overflow_o (wdt_ovf)
    );

    // register port decode, writes only while the core runs
    assign wr_wdt = REQ.wr & (REQ.addr == ADDR_WATCHDOG_CONTROL) & (s_reg.st == ST_RUN);
    assign wr_src = REQ.wr & (REQ.addr == ADDR_RESET_SOURCE) & (s_reg.st == ST_RUN);

    // sequencer, register writes and read data
    always_comb begin
        s_next = s_reg;
        if (s_reg.disarm != 3'h0) begin
            s_next.disarm = s_reg.disarm - 3'h1;
        end
        case (s_reg.st)
            ST_RUN: begin
                if (any_req) begin
                    // entry: registers to defaults, watchdog rearmed
                    s_next.st           = ST_HOLD;
                    s_next.cause        = req;
                    s_next.mon_sel      = 1'b1;
                    s_next.clk_loss_en  = 1'b0;
                    s_next.comp_en      = 1'b0;
                    s_next.cnv_en       = 1'b0;
                    s_next.wdt_active   = 1'b1;
                    s_next.wdt_lock     = 1'b0;
                    s_next.wdt_interval = WDT_INTERVAL_RST;
                    s_next.disarm       = 3'h0;
                end else begin
                    // watchdog command bytes
                    if (wr_wdt) begin
                        s_next.disarm = 3'h0;
                        if (REQ.wdata == WDT_CMD_ENABLE) begin
                            s_next.wdt_active = 1'b1;
                        end else if (REQ.wdata == WDT_CMD_DISARM) begin
                            s_next.disarm = WDT_DISARM_CLKS;
                        end else if (REQ.wdata == WDT_CMD_DISABLE) begin
                            // second byte only counts inside the window
                            if (s_reg.disarm != 3'h0 && !s_reg.wdt_lock) begin
                                s_next.wdt_active = 1'b0;
                            end
                        end else if (REQ.wdata == WDT_CMD_LOCK) begin
                            s_next.wdt_lock = 1'b1;
                        end else if (!REQ.wdata[BIT_WDT_MODE]) begin
                            s_next.wdt_interval = REQ.wdata[2:0];
                        end
                    end
                    // reset source enables
                    if (wr_src) begin
                        s_next.mon_sel     = REQ.wdata[BIT_POWER_FLAG];
                        s_next.clk_loss_en = REQ.wdata[BIT_CLK_LOSS];
                        s_next.comp_en     = REQ.wdata[BIT_COMP];
                        s_next.cnv_en      = REQ.wdata[BIT_CNV];
                    end
                end
            end
            ST_HOLD: begin
                // gather every source until all are gone and stretched
                s_next.cause = s_reg.cause | req;
                if (!any_req && !pin_busy && !supply_busy) begin
                    s_next.st = ST_EXIT;
                end
            end
            ST_EXIT: begin
                if (any_req) begin
                    s_next.st    = ST_HOLD;
                    s_next.cause = s_reg.cause | req;
                end else begin
                    // cause flags latched before execution resumes
                    s_next.st          = ST_RUN;
                    s_next.flag_power  = s_reg.cause.power;
                    s_next.flag_pin    = s_reg.cause.pin;
                    s_next.flag_wdt    = s_reg.cause.wdt;
                    s_next.clk_loss_en = s_reg.cause.clk_loss;
                    s_next.comp_en     = s_reg.cause.comp;
                    s_next.cnv_en      = s_reg.cause.cnv;
                end
            end
            default: begin
                s_next.st = ST_HOLD;
            end
        endcase

        // read data, valid in the cycle after the strobe
        s_next.rdata = 8'h00;
        if (REQ.rd) begin
            if (REQ.addr == ADDR_RESET_SOURCE) begin
                s_next.rdata[BIT_PIN_FLAG]   = s_reg.flag_pin;
                s_next.rdata[BIT_POWER_FLAG] = s_reg.flag_power;
                s_next.rdata[BIT_CLK_LOSS]   = s_reg.clk_loss_en;
                s_next.rdata[BIT_WDT_FLAG]   = s_reg.flag_wdt;
                s_next.rdata[BIT_COMP]       = s_reg.comp_en;
                s_next.rdata[BIT_CNV]        = s_reg.cnv_en;
            end else if (REQ.addr == ADDR_WATCHDOG_CONTROL) begin
                s_next.rdata[BIT_WDT_STATUS] = s_reg.wdt_active;
                s_next.rdata[2:0]            = s_reg.wdt_interval;
            end
        end

        // core controls; data memory sits outside this reset on purpose
        go_run            = (s_next.st == ST_RUN);
        s_next.core_rst_b = go_run;
        s_next.port_set   = ~go_run;
        s_next.exec_halt  = ~(go_run & CLK_STABLE);
        s_next.pin_oe     = req.power | supply_busy;
        s_next.cnv_adc    = s_next.cnv_en | CONVERT_START_INPUT;
    end

    // state register
    always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            s_reg <= SEQ_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops, except RST_PIN_OUT which is tied low
    assign RDATA          = s_reg.rdata;
    assign RST_PIN_OUT    = 1'b0;  // open drain, only ever pulls low
    assign RST_PIN_OE     = s_reg.pin_oe;
    assign CNV_TO_ADC     = s_reg.cnv_adc;
    assign CORE_RST_B     = s_reg.core_rst_b;
    assign EXEC_HALT      = s_reg.exec_halt;
    assign PORT_LATCH_SET = s_reg.port_set;

    // helper: clocks since the pin request was last seen
    logic [7:0] pin_gap;
    always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pin_gap <= 8'h00;
        end else if (req.pin) begin
            pin_gap <= 8'h00;
        end else if (pin_gap != 8'hFF) begin
            pin_gap <= pin_gap + 8'h01;
        end
    end

    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n_sync);

    pin_stretch_a: assert property ($rose(CORE_RST_B) && s_reg.cause.pin |-> pin_gap >= 8'h0C)
        else $error("core released too soon after reset pin");
    power_flag_a: assert property ($rose(CORE_RST_B) |-> s_reg.flag_power == s_reg.cause.power)
        else $error("power flag does not match reset cause");
    pin_drive_a: assert property (req.power |=> RST_PIN_OE)
        else $error("reset pin not driven during supply reset");
    halt_a: assert property (!CORE_RST_B |-> EXEC_HALT && PORT_LATCH_SET)
        else $error("execution or ports not held in reset");
    wdt_restore_a: assert property ($rose(CORE_RST_B) |-> s_reg.wdt_active
                                    && s_reg.wdt_interval == 3'h7)
        else $error("watchdog not restored after reset");
    wdt_enable_a: assert property (wr_wdt && REQ.wdata == 8'hA5 |=> s_reg.wdt_active)
        else $error("watchdog enable command ignored");
    wdt_disable_a: assert property (wr_wdt && REQ.wdata == 8'hDE && !s_reg.wdt_lock
        ##1 (wr_wdt && REQ.wdata == 8'hAD && !any_req) |=> !s_reg.wdt_active)
        else $error("back to back disable sequence failed");
    wdt_lock_a: assert property (s_reg.wdt_lock && s_reg.wdt_active |=> s_reg.wdt_active)
        else $error("locked watchdog was disabled");
    wdt_read_a: assert property (REQ.rd && REQ.addr == 8'h01 |=> RDATA == {3'h0,
        $past(s_reg.wdt_active), 1'b0, $past(s_reg.wdt_interval)})
        else $error("watchdog control read data wrong");
    comp_reset_a: assert property (s_reg.st == ST_RUN && s_reg.comp_en && !COMP_OUT
        |=> !CORE_RST_B ##0 !RST_PIN_OE)
        else $error("comparator reset not taken");
    wdt_reset_a: assert property (wdt_ovf && s_reg.st == ST_RUN |=> !CORE_RST_B
        ##[1:4] (s_reg.cause.wdt && !RST_PIN_OE))
        else $error("watchdog overflow did not reset");

    wdt_ovf_c: cover property (wdt_ovf && s_reg.st == ST_RUN);
    pin_reset_c: cover property ($rose(CORE_RST_B) && s_reg.cause.pin);
    disable_c: cover property ($fell(s_reg.wdt_active));
    supply_reset_c: cover property ($rose(CORE_RST_B) && s_reg.cause.power);
endmodule

// file: verif/pin_supply_model.sv
// reset pin with pull-up and supply monitor level
`timescale 1ns/1ns
module pin_supply_model (
    input  wire logic pull_low,  // outside circuit pulls pin
    input  wire logic drop,      // supply under threshold
    input  wire logic oe,        // block drives pin
    input  wire logic out,       // block pin data
    output logic      pin,       // resolved level
    output logic      low        // monitor output
);
    // pull-up unless a party drives low
    assign pin = !((oe && !out) || pull_low);
    assign low = drop;
endmodule

// file: verif/tb_reset_source_and_watchdog.sv
// self-checking bench for the reset and watchdog block
`timescale 1ns/1ns
module tb_reset_source_and_watchdog;
    import rst_wdt_pkg::*;
    logic clk = 0, rst_b = 0, pull = 0, drop = 0, miss = 0, comp = 1, cnv = 1, rd_d = 0;
    logic stab = 1, mon = 1;  // clock settled, monitor enable pin
    reg_req_s    req = '0;  // register port
    logic [7:0]  rdata, v;
    logic        pin, low, pout, poe, adc, core, halt, latch;
    logic [15:0] q[$];      // mask and expected value per read
    logic [7:0]  src[3] = '{8'h22, 8'h42, 8'h06};
    int n_fail = 0, tests_run = 0, seed = 32'h55306cc8, n;
    initial forever #10 clk = ~clk;
    reset_source_and_watchdog #(.SUPPLY_HOLD(20)) DUT (.CORE_CLK(clk), .RST_B(rst_b),
        .REQ(req), .RDATA(rdata), .SUPPLY_MONITOR_ENABLE_PIN(mon), .SUPPLY_LOW(low),
        .RST_PIN_IN(pin), .RST_PIN_OUT(pout), .RST_PIN_OE(poe), .CLK_MISSING(miss),
        .CLK_STABLE(stab), .COMP_OUT(comp), .CONVERT_START_INPUT(cnv), .CNV_TO_ADC(adc),
        .CORE_RST_B(core), .EXEC_HALT(halt), .PORT_LATCH_SET(latch));
    pin_supply_model partner (.pull_low(pull), .drop(drop), .oe(poe), .out(pout),
        .pin(pin), .low(low));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one bus cycle, signals held until the next edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clk);
    endtask
    // read with its expectation noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        q.push_back({m, e});
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // bounded wait for the core reset level
    task automatic wait_core(input logic lvl);
        n = 0;
        while (core !== lvl) begin
            @(posedge clk);
            n++;
            if (n > 3000) begin
                n_fail++;
                finish_test();
            end
        end
    endtask
    // read data stands the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= req.rd;
        if (rd_d) begin
            check(rdata & q[0][15:8], q[0][7:0]);
            void'(q.pop_front());
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        wait_core(1'b1);
        rd(ADDR_RESET_SOURCE, 8'h02, 8'h02);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h17);
        rd(8'h05, 8'hFF, 8'h00);
        v = {5'h00, 3'($random(seed))};
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, v);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, v | 8'h10);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, 8'h00);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_ENABLE);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        wait_core(1'b0);
        check({7'h00, n >= 60 && n <= 70}, 8'h01);
        @(posedge clk);
        check({6'h00, halt, latch}, 8'h03);
        check({7'h00, poe}, 8'h00);
        wait_core(1'b1);
        rd(ADDR_RESET_SOURCE, 8'h0A, 8'h08);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h17);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISARM);
        repeat (6) bus(1'b0, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISABLE);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h17);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISARM);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISABLE);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h07);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_ENABLE);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, 8'h83);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h17);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_LOCK);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISARM);
        bus(1'b1, 1'b0, ADDR_WATCHDOG_CONTROL, WDT_CMD_DISABLE);
        rd(ADDR_WATCHDOG_CONTROL, 8'hFF, 8'h17);
        // convert start passes to the converter while its reset is off
        cnv <= 1'b0;
        repeat (2) @(posedge clk);
        check({7'h00, adc}, 8'h00);
        cnv <= 1'b1;
        // comparator, convert start, clock loss in turn
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 1'b0, ADDR_RESET_SOURCE, src[i]);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            comp <= (i != 0);
            cnv <= (i != 1);
            miss <= (i == 2);
            wait_core(1'b0);
            check({7'h00, poe}, 8'h00);
            comp <= 1'b1;
            cnv <= 1'b1;
            miss <= 1'b0;
            wait_core(1'b1);
            rd(ADDR_RESET_SOURCE, 8'h6F, src[i] & 8'h64);
        end
        // fetch held off while the clock is not settled
        stab <= 1'b0;
        repeat (2) @(posedge clk);
        check({7'h00, halt}, 8'h01);
        stab <= 1'b1;
        repeat (2) @(posedge clk);
        check({7'h00, halt}, 8'h00);
        pull <= 1'b1;
        repeat (3) @(posedge clk);
        pull <= 1'b0;
        wait_core(1'b1);
        check({7'h00, n >= 12}, 8'h01);
        rd(ADDR_RESET_SOURCE, 8'h0B, 8'h01);
        mon <= 1'b0;
        drop <= 1'b1;
        repeat (3) @(posedge clk);
        check({6'h00, poe, core}, 8'h01);
        mon <= 1'b1;
        repeat (5) @(posedge clk);
        check({6'h00, poe, core}, 8'h02);
        drop <= 1'b0;
        wait_core(1'b1);
        check({7'h00, n >= 20}, 8'h01);
        rd(ADDR_RESET_SOURCE, 8'h02, 8'h02);
        finish_test();
    end
endmodule
